// *** svm_pkg.sv ***
// Purpose: shared types and constants of the SIMD multiply unit
// Assumes: 128-bit quadword registers, 64-bit doubleword registers
// Notes: float formats use round to nearest even, subnormals flush to zero
package svm_pkg;
    // ************************************************************
    // register and lane geometry
    // ************************************************************
    localparam int SVM_QUAD_BITS = 128;
    localparam int SVM_DBL_BITS = 64;
    localparam int SVM_WORD_BITS = 32;
    localparam int SVM_ROUND_GUARD = 3;
    localparam int SVM_IDX_BITS = 3;

    // ************************************************************
    // float formats
    // ************************************************************
    localparam int SVM_F32_FRAC = 23;
    localparam int SVM_F32_BIAS = 127;
    localparam int SVM_F32_EMAX = 255;
    localparam int SVM_F64_FRAC = 52;
    localparam int SVM_F64_BIAS = 1023;
    localparam int SVM_F64_EMAX = 2047;
    localparam logic [63:0] SVM_F32_QNAN = 64'h0000_0000_7FC0_0000;
    localparam logic [63:0] SVM_F64_QNAN = 64'h7FF8_0000_0000_0000;
    localparam logic [63:0] SVM_F32_ONE = 64'h0000_0000_3F80_0000;
    localparam logic [63:0] SVM_F32_NEG_ZERO = 64'h0000_0000_8000_0000;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic SVM_SAT_RESET = 1'b0;
    localparam logic [127:0] SVM_DATA_RESET = 128'h0;

    typedef enum logic [3:0] {
        LANE_MULTIPLY, LANE_MULTIPLY_ACCUMULATE, LANE_MULTIPLY_SUBTRACT,
        WIDENING_MULTIPLY, WIDENING_MULTIPLY_ACCUMULATE, WIDENING_MULTIPLY_SUBTRACT,
        FUSED_MULTIPLY_ADD, FUSED_MULTIPLY_SUBTRACT,
        SAT_DOUBLE_HIGH_HALF_MULTIPLY, SAT_DOUBLE_HIGH_HALF_MULTIPLY_ROUNDED,
        SAT_DOUBLE_WIDENING_MULTIPLY, SAT_DOUBLE_WIDENING_ACCUMULATE,
        SAT_DOUBLE_WIDENING_SUBTRACT
    } svm_op_t;

    typedef enum logic [2:0] {ELEM_I8, ELEM_I16, ELEM_I32, ELEM_F32, ELEM_F64} svm_elem_t;
    typedef enum logic [1:0] {RW_WORD, RW_DOUBLE, RW_QUAD} svm_rw_t;

    typedef struct packed {
        logic valid;
        svm_op_t op;
        svm_elem_t elem;
        logic isUnsigned;
        svm_rw_t regWidth;
        logic byScalar;
        logic [SVM_IDX_BITS-1:0] scalarIdx;
        logic [127:0] opA;
        logic [127:0] opB;
        logic [127:0] dest;
    } svm_req_t;

    typedef struct packed {
        logic valid;
        logic illegal;
        logic [127:0] data;
    } svm_resp_t;

    typedef struct packed {
        logic resValid;
        logic resIllegal;
        logic [127:0] resData;
        logic stickySat;
    } svm_state_t;
endpackage

// *** svm_mul_unit.sv ***
// Purpose: lane-parallel SIMD multiply datapath with one result register
// Assumes: issue logic on the same clock, already resolved any condition
// Notes: answer one enabled edge after a valid request
// Operation
// - plain multiply, each lane times the same lane, to same lane.
// - multiply-accumulate adds the lane product to the destination lane.
// - multiply-subtract takes the lane product from the destination lane.
// - fused multiply-add accumulates exact lane products into destination.
// - fused multiply-subtract takes exact lane products from destination.
// - fused forms round once; single precision and doubleword double.
// - single-precision fused forms run on word, doubleword and quadword registers.
// - widening forms read doubleword sources, write double-width quadword lanes.
// - by-scalar multiply uses one selected doubleword lane for all lanes.
// - by-scalar accumulate adds lane-times-scalar to destination lane.
// - by-scalar subtract takes lane-times-scalar from destination lane.
// - non-widening scalar forms take 16, 32-bit integer or single float.
// - widening scalar forms take signed or unsigned 16 or 32-bit only.
// - scalar lane index comes with the instruction.
// - doubling high-half multiply on signed 16 or 32-bit lanes.
// - rounded high-half variant rounds, plain variant truncates.
// - doubling widening multiply gives double-width signed quadword lanes.
// - doubling widening accumulate adds doubled product to destination.
// - doubling widening subtract takes doubled product from destination.
// - saturating overflow clamps the lane and sets the sticky flag.
`timescale 1ns/1ps
module svm_mul_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire svm_pkg::svm_req_t req,
    input wire logic satClear,
    output svm_pkg::svm_resp_t resp,
    output logic stickySat
);
    import svm_pkg::*;

    // ************************************************************
    // lane helpers
    // ************************************************************
    // extract a lane, sign or zero extended
    function automatic logic signed [79:0] getLane(input logic [127:0] v, input int esz,
                                                   input int idx, input logic uns);
        logic [127:0] s;
        logic [79:0] m;
        s = v >> (idx * esz);
        m = {16'h0, s[63:0]} & ((80'h1 << esz) - 80'h1);
        if (!uns && m[esz-1]) begin
            m = m - (80'h1 << esz);
        end
        return signed'(m);
    endfunction

    // replace one lane with the low bits of x
    function automatic logic [127:0] putLane(input logic [127:0] v, input int esz,
                                             input int idx, input logic [79:0] x);
        logic [127:0] mask;
        mask = ((128'h1 << esz) - 128'h1) << (idx * esz);
        return (v & ~mask) | (({48'h0, x} << (idx * esz)) & mask);
    endfunction

    // clamp a signed value to w bits, flag on overflow
    function automatic logic signed [79:0] satClamp(input logic signed [79:0] x, input int w,
                                                    output logic hit);
        logic signed [79:0] hi;
        logic signed [79:0] lo;
        hi = signed'((80'h1 << (w - 1)) - 80'h1);
        lo = -hi - 80'sh1;
        hit = (x > hi) || (x < lo);
        return (x > hi) ? hi : ((x < lo) ? lo : x);
    endfunction

    // unpack a float, subnormals flushed to zero
    function automatic void fpUnpack(input logic dbl, input logic [63:0] x, output logic s,
                                     output int e, output logic [52:0] m, output logic nan,
                                     output logic inf);
        logic [51:0] f;
        int emax;
        emax = dbl ? SVM_F64_EMAX : SVM_F32_EMAX;
        s = dbl ? x[63] : x[31];
        e = dbl ? int'(x[62:52]) : int'(x[30:23]);
        f = dbl ? x[51:0] : {29'h0, x[22:0]};
        nan = (e == emax) && (f != 52'h0);
        inf = (e == emax) && (f == 52'h0);
        m = (e == 0) ? 53'h0 : (dbl ? {1'b1, f} : {29'h0, 1'b1, f[22:0]});
    endfunction

    // pack sign, biased exponent and fraction
    function automatic logic [63:0] fpPack(input logic dbl, input logic s, input int e,
                                           input logic [111:0] q);
        return dbl ? {s, e[10:0], q[51:0]} : {32'h0, s, e[7:0], q[22:0]};
    endfunction

    // right shift keeping a sticky bit
    function automatic logic [111:0] shrSticky(input logic [111:0] x, input int d);
        if (d >= 112) begin
            return {111'h0, |x};
        end
        return (x >> d) | {111'h0, |(x & ((112'h1 << d) - 112'h1))};
    endfunction

    // fused multiply-add, c + (+/-)a*b with one rounding
    function automatic logic [63:0] fpFma(input logic dbl, input logic [63:0] a,
                                          input logic [63:0] b, input logic [63:0] c,
                                          input logic negP);
        logic sa, sb, sc, sp, sr, na, nb, nc, ia, ib, ic, big1;
        logic [52:0] ma, mb, mc;
        logic [111:0] pv, cv, bigV, smlV, r, q, rem, half;
        int ea, eb, ec, fb, bias, emax, pe, ex, d, lead, re, sh;
        fb = dbl ? SVM_F64_FRAC : SVM_F32_FRAC;
        bias = dbl ? SVM_F64_BIAS : SVM_F32_BIAS;
        emax = dbl ? SVM_F64_EMAX : SVM_F32_EMAX;
        fpUnpack(dbl, a, sa, ea, ma, na, ia);
        fpUnpack(dbl, b, sb, eb, mb, nb, ib);
        fpUnpack(dbl, c, sc, ec, mc, nc, ic);
        sp = sa ^ sb ^ negP;
        if (na || nb || nc || ((ia || ib) && (ma == 53'h0 || mb == 53'h0) && !(ia && ib))
            || ((ia || ib) && ic && sp != sc)) begin
            return dbl ? SVM_F64_QNAN : SVM_F32_QNAN;
        end
        if (ia || ib) begin
            return fpPack(dbl, sp, emax, 112'h0);
        end
        if (ic) begin
            return fpPack(dbl, sc, emax, 112'h0);
        end
        if (ma == 53'h0 || mb == 53'h0) begin
            return (mc == 53'h0) ? fpPack(dbl, sp & sc, 0, 112'h0) : c;
        end
        // keep the whole product, align the smaller of product and addend to the larger
        pv = (112'(ma) * 112'(mb)) << SVM_ROUND_GUARD;
        cv = (112'(mc) << fb) << SVM_ROUND_GUARD;
        pe = ea + eb - bias;
        d = (mc == 53'h0) ? 0 : pe - ec;
        big1 = (d >= 0);
        ex = big1 ? pe : ec;
        bigV = big1 ? pv : cv;
        smlV = big1 ? shrSticky(cv, d) : shrSticky(pv, -d);
        sr = big1 ? sp : sc;
        if (sp == sc) begin
            r = bigV + smlV;
        end else if (bigV >= smlV) begin
            r = bigV - smlV;
        end else begin
            r = smlV - bigV;
            sr = !sr;
        end
        if (r == 112'h0) begin
            return fpPack(dbl, 1'b0, 0, 112'h0);
        end
        lead = 0;
        for (int k = 0; k < 112; k++) begin
            if (r[k]) begin
                lead = k;
            end
        end
        re = lead + ex - 2 * fb - SVM_ROUND_GUARD;
        sh = lead - fb;
        // single rounding, nearest even
        if (sh > 0) begin
            q = r >> sh;
            rem = r & ((112'h1 << sh) - 112'h1);
            half = 112'h1 << (sh - 1);
            if (rem > half || (rem == half && q[0])) begin
                q = q + 112'h1;
            end
        end else begin
            q = r << (-sh);
        end
        if (q[fb+1]) begin
            q = q >> 1;
            re = re + 1;
        end
        if (re >= emax) begin
            return fpPack(dbl, sr, emax, 112'h0);
        end
        if (re <= 0) begin
            return fpPack(dbl, sr, 0, 112'h0);
        end
        return fpPack(dbl, sr, re, q);
    endfunction

    // ************************************************************
    // state and decode
    // ************************************************************
    svm_state_t st_q, st_d;
    int esz, dw, nLanes, idx;
    logic isFp, dbl, wide, fused, satOp, plainOp, bad, satHit, hit1, hit2;
    logic [127:0] res;
    logic signed [79:0] a, b, dv, p, r, t;
    logic [63:0] fa, fb64, fd, fp;

    // ************************************************************
    // lane datapath
    // ************************************************************
    always_comb begin
        st_d = st_q;
        st_d.resValid = 1'b0;
        st_d.resIllegal = 1'b0;
        res = 128'h0;
        satHit = 1'b0;
        hit1 = 1'b0;
        hit2 = 1'b0;
        a = '0;
        b = '0;
        dv = '0;
        p = '0;
        r = '0;
        t = '0;
        fa = '0;
        fb64 = '0;
        fd = '0;
        fp = '0;

        esz = (req.elem == ELEM_I8) ? 8 : ((req.elem == ELEM_I16) ? 16 :
              ((req.elem == ELEM_F64) ? 64 : 32));
        isFp = (req.elem == ELEM_F32) || (req.elem == ELEM_F64);
        dbl = (req.elem == ELEM_F64);
        fused = (req.op == FUSED_MULTIPLY_ADD) || (req.op == FUSED_MULTIPLY_SUBTRACT);
        satOp = req.op >= SAT_DOUBLE_HIGH_HALF_MULTIPLY;
        plainOp = req.op <= LANE_MULTIPLY_SUBTRACT;
        wide = (req.op >= SAT_DOUBLE_WIDENING_MULTIPLY) ||
               ((req.op >= WIDENING_MULTIPLY) && (req.op <= WIDENING_MULTIPLY_SUBTRACT));
        dw = wide ? 2 * esz : esz;
        nLanes = wide ? SVM_DBL_BITS / esz : ((req.regWidth == RW_QUAD) ? SVM_QUAD_BITS / esz :
                 ((req.regWidth == RW_WORD) ? SVM_WORD_BITS / esz : SVM_DBL_BITS / esz));
        idx = int'(req.scalarIdx);

        bad = (isFp && !fused && !(plainOp && !dbl)) || (fused && !isFp)
              || (dbl && req.regWidth != RW_DOUBLE)
              || (req.regWidth == RW_WORD && !(fused && !dbl))
              || (wide && isFp) || (satOp && (req.isUnsigned || esz == 8))
              || (req.byScalar && (esz == 8 || fused))
              || (req.byScalar && idx >= SVM_DBL_BITS / esz);

        for (int i = 0; i < 16; i++) begin
            if (i < nLanes && !bad) begin
                // scalar operand shared by all lanes
                a = getLane(req.opA, esz, i, req.isUnsigned || isFp);
                b = getLane(req.opB, esz, req.byScalar ? idx : i, req.isUnsigned || isFp);
                dv = getLane(req.dest, dw, i, req.isUnsigned || isFp);
                p = a * b;
                fa = a[63:0];
                fb64 = b[63:0];
                fd = dv[63:0];
                case (req.op)
                    LANE_MULTIPLY, WIDENING_MULTIPLY: begin
                        r = p;
                        fp = fpFma(1'b0, fa, fb64, SVM_F32_NEG_ZERO, 1'b0);
                    end
                    LANE_MULTIPLY_ACCUMULATE, WIDENING_MULTIPLY_ACCUMULATE: begin
                        r = dv + p;
                        fp = fpFma(1'b0, fpFma(1'b0, fa, fb64, SVM_F32_NEG_ZERO, 1'b0),
                                   SVM_F32_ONE, fd, 1'b0);
                    end
                    LANE_MULTIPLY_SUBTRACT, WIDENING_MULTIPLY_SUBTRACT: begin
                        r = dv - p;
                        fp = fpFma(1'b0, fpFma(1'b0, fa, fb64, SVM_F32_NEG_ZERO, 1'b0),
                                   SVM_F32_ONE, fd, 1'b1);
                    end
                    FUSED_MULTIPLY_ADD: begin
                        fp = fpFma(dbl, fa, fb64, fd, 1'b0);
                    end
                    FUSED_MULTIPLY_SUBTRACT: begin
                        fp = fpFma(dbl, fa, fb64, fd, 1'b1);
                    end
                    SAT_DOUBLE_HIGH_HALF_MULTIPLY, SAT_DOUBLE_HIGH_HALF_MULTIPLY_ROUNDED: begin
                        t = (p <<< 1) + ((req.op == SAT_DOUBLE_HIGH_HALF_MULTIPLY_ROUNDED) ?
                            signed'(80'h1 << (esz - 1)) : 80'sh0);
                        r = satClamp(t >>> esz, esz, hit1);
                    end
                    SAT_DOUBLE_WIDENING_MULTIPLY: begin
                        r = satClamp(p <<< 1, dw, hit1);
                    end
                    SAT_DOUBLE_WIDENING_ACCUMULATE: begin
                        t = satClamp(p <<< 1, dw, hit1);
                        r = satClamp(dv + t, dw, hit2);
                    end
                    SAT_DOUBLE_WIDENING_SUBTRACT: begin
                        t = satClamp(p <<< 1, dw, hit1);
                        r = satClamp(dv - t, dw, hit2);
                    end
                    default: begin
                        r = '0;
                    end
                endcase
                res = putLane(res, dw, i, isFp ? {16'h0, fp} : r);

                satHit = satHit | hit1 | hit2;
            end
        end

        // clear first, so a same-cycle overflow wins
        if (satClear) begin
            st_d.stickySat = 1'b0;
        end

        // every valid request is answered; refused ones return zero data
        if (req.valid) begin
            st_d.resValid = 1'b1;
            st_d.resIllegal = bad;
            st_d.resData = bad ? SVM_DATA_RESET : res;
            if (satOp && satHit && !bad) begin
                st_d.stickySat = 1'b1;
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '{resValid: 1'b0, resIllegal: 1'b0, resData: SVM_DATA_RESET,
                      stickySat: SVM_SAT_RESET};
        end else if (clkEn) begin
            st_q <= st_d;
        end
    end

    // outputs straight from the state register
    assign resp.valid = st_q.resValid;
    assign resp.illegal = st_q.resIllegal;
    assign resp.data = st_q.resData;
    assign stickySat = st_q.stickySat;
endmodule

// *** svm_issue_model.sv ***
// Purpose: issue-side model feeding the unit
// Assumes: same clock as the unit
// Notes: idle fields toggle, valid low
`timescale 1ns/1ps
module svm_issue_model (
    input wire logic clk,
    input wire logic clkEn,
    input wire logic cmdValid,
    input wire logic cmdCond,
    input wire svm_pkg::svm_req_t cmdReq,
    output svm_pkg::svm_req_t req
);
    import svm_pkg::*;
    initial begin
        req = '0;
    end
    always @(posedge clk) begin
        if (clkEn) begin
            if (cmdValid && cmdCond) begin
                req <= cmdReq;
            end else begin
                req <= {1'h0, ~req[$bits(svm_req_t)-2:0]};
            end
        end
    end
endmodule

// *** svm_mul_unit_asserts.sv ***
// Purpose: port checks of the unit
// Assumes: one clock, synchronous reset
// Notes: bound in at the foot
`timescale 1ns/1ps
module svm_mul_unit_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire svm_pkg::svm_req_t req,
    input wire logic satClear,
    input wire svm_pkg::svm_resp_t resp,
    input wire logic stickySat
);
    import svm_pkg::*;
    logic satOp, taken;
    // saturating op decode, request taken at this edge
    assign satOp = req.op >= SAT_DOUBLE_HIGH_HALF_MULTIPLY;
    assign taken = clkEn && req.valid;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ************************************************************
    // request and answer steps
    // ************************************************************
    sequence sTopClamp;
        stickySat && resp.data[127:112] == 16'h7FFF;
    endsequence
    chk_answer_next: assert property (taken |=> resp.valid)
        else $error("answer late");
    chk_no_extra: assert property (clkEn && !req.valid |=> !resp.valid)
        else $error("stray answer");
    chk_refuse_zero: assert property (resp.valid && resp.illegal |-> resp.data == '0)
        else $error("refused data not zero");
    chk_scalar_byte: assert property (taken && req.byScalar && req.elem == ELEM_I8
        |=> resp.illegal) else $error("byte scalar not refused");
    chk_sat_unsigned: assert property (taken && satOp && req.isUnsigned
        |=> resp.illegal) else $error("unsigned sat not refused");
    chk_fused_int: assert property (taken && req.op inside {FUSED_MULTIPLY_ADD,
        FUSED_MULTIPLY_SUBTRACT} && req.elem <= ELEM_I32 |=> resp.illegal)
        else $error("integer fused not refused");
    chk_plain_flag: assert property (taken && !satOp && !satClear && !stickySat
        |=> !stickySat) else $error("plain op set the flag");
    chk_sticky_hold: assert property (stickySat && !satClear |=> stickySat)
        else $error("flag dropped");
    chk_clear_flag: assert property (clkEn && satClear && !(req.valid && satOp)
        |=> !stickySat) else $error("flag not cleared");
    chk_freeze_all: assert property (!clkEn |=> $stable(resp) && $stable(stickySat))
        else $error("moved while frozen");
    chk_high_clamp: assert property (taken && req.op == SAT_DOUBLE_HIGH_HALF_MULTIPLY
        && req.elem == ELEM_I16 && !req.isUnsigned && !req.byScalar && req.regWidth == RW_QUAD
        && {req.opA[127:112], req.opB[127:112]} == 32'h8000_8000 |=> sTopClamp)
        else $error("overflow not clamped");
endmodule
bind svm_mul_unit svm_mul_unit_asserts u_asserts (.clk(clk), .rst(rst), .clkEn(clkEn),
    .req(req), .satClear(satClear), .resp(resp), .stickySat(stickySat));

// *** svm_mul_unit_tb_top.sv ***
// Purpose: self-checking bench
// Assumes: float results worked by hand
// Notes: requests go through the issue model
`timescale 1ns/1ps
module svm_mul_unit_tb_top;
    import svm_pkg::*;
    localparam logic [127:0] OPA = 128'h8000_7FFF_FFFF_0003_8000_0000_4000_1234;
    localparam logic [127:0] OPB = 128'h8000_7FFF_0002_FFFD_8000_0000_4000_00F0;
    localparam logic [127:0] DST = 128'h7FFF_FFF0_8000_0010_0123_4567_89AB_CDEF;
    logic clk, rst, clkEn, satClear, cmdValid, cmdCond, stickySat, expSticky;
    svm_req_t cmdReq, req;
    svm_resp_t resp;
    int miscompares = 0;
    int checks = 0;
    svm_issue_model u_issue (.clk(clk), .clkEn(clkEn), .cmdValid(cmdValid),
        .cmdCond(cmdCond), .cmdReq(cmdReq), .req(req));
    svm_mul_unit u_dut (.clk(clk), .rst(rst), .clkEn(clkEn), .req(req),
        .satClear(satClear), .resp(resp), .stickySat(stickySat));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // ************************************************************
    // reporting
    // ************************************************************
    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ************************************************************
    // lane reference model
    // ************************************************************
    function automatic logic signed [127:0] lane(logic [127:0] v, int i, int w, logic u);
        logic signed [127:0] x;
        x = v >> (i * w);
        return u ? x & ((128'sh1 << w) - 128'sh1) : (x <<< (128 - w)) >>> (128 - w);
    endfunction
    function automatic logic signed [127:0] sat(logic signed [127:0] x, int w, inout logic ovf);
        logic signed [127:0] hi;
        hi = (128'sh1 <<< (w - 1)) - 128'sh1;
        if (x > hi || x < -hi - 128'sh1) begin
            ovf = 1'h1;
            return (x > hi) ? hi : -hi - 128'sh1;
        end
        return x;
    endfunction
    function automatic logic [127:0] ref_int(svm_req_t r, output logic ovf);
        logic signed [127:0] a, b, d, p;
        int w, ow, n;
        logic wide;
        ref_int = '0;
        ovf = 1'h0;
        w = 8 << r.elem;
        wide = r.op >= SAT_DOUBLE_WIDENING_MULTIPLY ||
            r.op inside {[WIDENING_MULTIPLY:WIDENING_MULTIPLY_SUBTRACT]};
        ow = wide ? 2 * w : w;
        n = wide ? 64 / w : ((r.regWidth == RW_QUAD) ? 128 : 64) / w;
        for (int i = 0; i < n; i++) begin
            a = lane(r.opA, i, w, r.isUnsigned);
            b = lane(r.opB, r.byScalar ? int'(r.scalarIdx) : i, w, r.isUnsigned);
            d = lane(r.dest, i, ow, r.isUnsigned);
            p = a * b;
            case (r.op)
                LANE_MULTIPLY_ACCUMULATE, WIDENING_MULTIPLY_ACCUMULATE: p = d + p;
                LANE_MULTIPLY_SUBTRACT, WIDENING_MULTIPLY_SUBTRACT: p = d - p;
                SAT_DOUBLE_HIGH_HALF_MULTIPLY: p = sat((2 * p) >>> w, w, ovf);
                SAT_DOUBLE_HIGH_HALF_MULTIPLY_ROUNDED: begin
                    p = sat((2 * p + (128'sh1 <<< (w - 1))) >>> w, w, ovf);
                end
                SAT_DOUBLE_WIDENING_MULTIPLY: p = sat(2 * p, ow, ovf);
                SAT_DOUBLE_WIDENING_ACCUMULATE: begin
                    p = sat(2 * p, ow, ovf);
                    p = sat(d + p, ow, ovf);
                end
                SAT_DOUBLE_WIDENING_SUBTRACT: begin
                    p = sat(2 * p, ow, ovf);
                    p = sat(d - p, ow, ovf);
                end
                default: p = p;
            endcase
            ref_int = ref_int | ((p & ((128'h1 << ow) - 1)) << (i * ow));
        end
    endfunction
    // ************************************************************
    // request driving
    // ************************************************************
    task automatic issue(input svm_req_t r, input logic cond, output svm_resp_t got);
        int n;
        @(posedge clk);
        cmdReq <= r;
        cmdValid <= 1'h1;
        cmdCond <= cond;
        @(posedge clk);
        cmdValid <= 1'h0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (resp.valid !== 1'h1 && n < 4);
        got = resp;
        if (cond && resp.valid !== 1'h1) begin
            check("answer", 1'h1, resp.valid);
            wrap_up();
        end
        if (cond) begin
            check("latency", 1, n);
        end
    endtask
    task automatic run(input svm_req_t r, input logic [127:0] exp, input logic ill,
        input logic ovf);
        svm_resp_t got;
        issue(r, 1'h1, got);
        expSticky = expSticky | ovf;
        check("data", exp, got.data);
        check("illegal", ill, got.illegal);
        check("flag", expSticky, stickySat);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_cond();
        svm_resp_t got;
        issue('{1'h1, LANE_MULTIPLY, ELEM_I16, 1'h0, RW_QUAD, 1'h0, 3'h0, OPA, OPB, DST},
            1'h0, got);
        check("skipped op", 1'h0, got.valid);
    endtask
    task automatic t_refused();
        svm_req_t bad [4];
        bad[0] = '{1'h1, LANE_MULTIPLY, ELEM_I8, 1'h0, RW_QUAD, 1'h1, 3'h0, OPA, OPB, DST};
        bad[1] = '{1'h1, SAT_DOUBLE_HIGH_HALF_MULTIPLY, ELEM_I16, 1'h1, RW_QUAD, 1'h0, 3'h0,
            OPA, OPB, DST};
        bad[2] = '{1'h1, FUSED_MULTIPLY_ADD, ELEM_I32, 1'h0, RW_QUAD, 1'h0, 3'h0, OPA, OPB, DST};
        bad[3] = '{1'h1, LANE_MULTIPLY, ELEM_I32, 1'h0, RW_QUAD, 1'h1, 3'h2, OPA, OPB, DST};
        foreach (bad[i]) begin
            run(bad[i], 128'h0, 1'h1, 1'h0);
        end
    endtask
    task automatic t_int_ops();
        svm_req_t r;
        logic ovf;
        logic [127:0] exp;
        for (int o = 0; o < 13; o++) begin
            for (int e = 0; e < 3; e++) begin
                for (int s = 0; s < 2; s++) begin
                    if (o == 6 || o == 7 || (e == 0 && (s == 1 || o >= 8))) begin
                        continue;
                    end
                    r = '{1'h1, svm_op_t'(o), svm_elem_t'(e), 1'h0,
                        s ? RW_DOUBLE : RW_QUAD, s[0], 3'h0, OPA, OPB, DST};
                    r.isUnsigned = o >= 3 && o <= 5 && e == 1;
                    r.scalarIdx = 3'(64 / (8 << e) - 1);
                    exp = ref_int(r, ovf);
                    run(r, exp, 1'h0, ovf);
                end
            end
        end
    endtask
    task automatic t_fused();
        svm_req_t f [5];
        logic [127:0] e [5];
        f[0] = {1'h1, FUSED_MULTIPLY_ADD, ELEM_F32, 1'h0, RW_QUAD, 1'h0, 3'h0,
            {8{32'h3F80_0800}}, {4{32'hBF80_0000}}};
        e[0] = {4{32'h3A00_0400}};
        f[1] = {1'h1, FUSED_MULTIPLY_SUBTRACT, ELEM_F32, 1'h0, RW_DOUBLE, 1'h0, 3'h0,
            {12{32'h3F80_0000}}};
        e[1] = 128'h0;
        f[2] = f[1];
        f[2].op = FUSED_MULTIPLY_ADD;
        f[2].regWidth = RW_WORD;
        e[2] = 128'h4000_0000;
        f[3] = {1'h1, FUSED_MULTIPLY_ADD, ELEM_F64, 1'h0, RW_DOUBLE, 1'h0, 3'h0,
            {6{64'h3FF0_0000_0000_0000}}};
        e[3] = 128'h4000_0000_0000_0000;
        f[4] = f[1];
        f[4].op = LANE_MULTIPLY;
        e[4] = {2{32'h3F80_0000}};
        foreach (f[i]) begin
            run(f[i], e[i], 1'h0, 1'h0);
        end
    endtask
    task automatic t_clear();
        @(posedge clk);
        clkEn <= 1'h0;
        satClear <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        check("frozen flag", 1'h1, stickySat);
        @(posedge clk);
        clkEn <= 1'h1;
        @(posedge clk);
        satClear <= 1'h0;
        #1;
        check("cleared flag", 1'h0, stickySat);
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        clkEn = 1'h1;
        rst = 1'h1;
        satClear = 1'h0;
        cmdValid = 1'h0;
        cmdCond = 1'h0;
        cmdReq = '0;
        expSticky = 1'h0;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        #1;
        check("reset data", 128'h0, resp.data);
        check("reset flag", 1'h0, stickySat);
        t_cond();
        t_refused();
        t_int_ops();
        t_fused();
        t_clear();
        wrap_up();
    end
endmodule
